// ### dv/sbd_agent.sv
`timescale 1ns/10ps
`default_nettype none

// Far-side bus agent: takes the data bus, sends beats and postpones at random.
module sbd_agent (
	// Clock.
	input  wire logic        clk,
	// Pin drive values and enable.
	output logic      [63:0] a_data_n,
	output logic      [3:0]  a_par_n,
	output logic             a_valid_n,
	output logic             a_busy_n,
	output logic             a_oe,
	output logic             post_n
);
	// Lines start released and idle.
	initial begin
		{a_data_n, a_par_n, a_valid_n, a_busy_n} = '1;
		a_oe = 1'b0;
	end

	// Postponement comes and goes at random, changed just after each rising edge.
	initial begin
		post_n = 1'b1;
		forever begin
			@(posedge clk);
			#1;
			post_n = ($urandom % 4) != 0;
		end
	end

	// Take the bus; the in-use line falls with the enable.
	task grab();
		a_busy_n = 1'b0;
		a_oe = 1'b1;
		@(posedge clk);
		#1;
	endtask

	// One valid beat, then an idle clock carrying junk data.
	task beat(input logic [63:0] d, input logic [3:0] p);
		a_data_n = ~d;
		a_par_n = ~p;
		a_valid_n = 1'b0;
		@(posedge clk);
		#1;
		a_valid_n = 1'b1;
		a_data_n = d;
		@(posedge clk);
		#1;
	endtask

	// Give the bus back.
	task release_bus();
		a_busy_n = 1'b1;
		a_oe = 1'b0;
		@(posedge clk);
		#1;
	endtask
endmodule

`default_nettype wire

// ### dv/test_system_bus_data_phase.sv
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench with one far-side agent sharing the bus.
module test_system_bus_data_phase;
	logic                  clk = 0, sys_rst = 1, tx_req = 0, tx_valid = 0, tx_last = 0;
	logic [63:0]           tx_data = '0, data_n_in, data_n_out, a_d;
	logic [3:0]            tx_invert = '0, data_parity_n_in, data_parity_n_out, a_p;
	logic [3:0]            data_invert_n_in, data_invert_n_out;
	logic                  tx_ready, tx_owned, rx_valid, rx_parity_err, rx_postponed;
	logic                  data_n_oe, data_parity_n_oe, data_invert_n_oe, a_v, a_b, a_oe;
	logic                  data_valid_n_in, data_valid_n_out, data_valid_n_oe;
	logic                  data_bus_in_use_n_in, data_bus_in_use_n_out, data_bus_in_use_n_oe;
	logic                  completion_postponed_n, post_exp, chk_ok;
	logic [71:0]           exp_tx;
	sbd_pkg::sbd_beat_type rx_beat;
	logic [71:0]           txq[$];
	logic [72:0]           rxq[$];
	int                    error_cnt = 0, samples_checked = 0;

	always #25 clk = ~clk;

	// Released lines float high through the bus termination.
	assign data_n_in = (data_n_oe ? data_n_out : '1) & (a_oe ? a_d : '1);
	assign data_parity_n_in = (data_parity_n_oe ? data_parity_n_out : '1) & (a_oe ? a_p : '1);
	assign data_invert_n_in = data_invert_n_oe ? data_invert_n_out : '1;
	assign data_valid_n_in = (data_valid_n_oe ? data_valid_n_out : 1'b1) & (a_oe ? a_v : 1'b1);
	assign data_bus_in_use_n_in = (data_bus_in_use_n_oe ? data_bus_in_use_n_out : 1'b1) & a_b;

	sbd_data_phase u_dut (.clk, .sys_rst, .tx_req, .tx_valid, .tx_data, .tx_invert, .tx_last,
		.tx_ready, .tx_owned, .rx_beat, .rx_valid, .rx_parity_err, .rx_postponed,
		.data_n_in, .data_n_out, .data_n_oe, .data_parity_n_in, .data_parity_n_out,
		.data_parity_n_oe, .data_invert_n_in, .data_invert_n_out, .data_invert_n_oe,
		.data_valid_n_in, .data_valid_n_out, .data_valid_n_oe, .data_bus_in_use_n_in,
		.data_bus_in_use_n_out, .data_bus_in_use_n_oe, .completion_postponed_n);

	sbd_agent ag (.clk, .a_data_n(a_d), .a_par_n(a_p), .a_valid_n(a_v), .a_busy_n(a_b),
		.a_oe, .post_n(completion_postponed_n));

	// Even parity of each 16-bit group.
	function automatic logic [3:0] par(input logic [63:0] w);
		for (int g = 0; g < 4; g++) par[g] = ^w[16*g +: 16];
	endfunction

	// Pin image of a sent beat: data, parity and inversion lines.
	function automatic logic [71:0] txexp(input logic [63:0] d, input logic [3:0] v);
		for (int g = 0; g < 4; g++) d[16*g +: 16] ^= {16{v[g]}};
		txexp = {~d, ~par(d), ~v};
	endfunction

	// Counts one comparison and reports it when the seen value differs.
	task automatic chk(input logic [72:0] seen, input logic [72:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task stop_test();
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A wait that runs out of cycles counts as a mismatch.
	task timeout();
		error_cnt++;
		stop_test();
	endtask

	// Core sends n beats with random idle clocks between them.
	task tx_send(input int n);
		tx_req = 1'b1;
		for (int w = 0; tx_owned !== 1'b1; w++) begin
			if (w > 60)
				timeout();
			@(posedge clk);
			#1;
		end
		tx_req = 1'b0;
		for (int i = 0; i < n; i++) begin
			if ($urandom % 2) begin
				tx_valid = 1'b0;
				@(posedge clk);
				#1;
			end
			{tx_valid, tx_last, tx_invert} = {1'b1, i == n - 1, 4'($urandom)};
			tx_data = {$urandom, $urandom};
			for (int w = 0; tx_ready !== 1'b1; w++) begin
				if (w > 20)
					timeout();
				@(posedge clk);
				#1;
			end
			txq.push_back(txexp(tx_data, tx_invert));
			@(posedge clk);
			#1;
		end
		{tx_valid, tx_last} = 2'h0;
	endtask

	// Wait until nobody holds the bus before the agent may take it.
	task wait_free();
		for (int w = 0; data_bus_in_use_n_in !== 1'b1 || data_n_oe !== 1'b0; w++) begin
			if (w > 20)
				timeout();
			@(posedge clk);
			#1;
		end
	endtask

	// Agent sends n beats; when bad is set, every beat carries a flipped parity bit.
	task ag_send(input int n, input bit bad);
		logic [63:0] d;
		logic [3:0]  p;
		ag.grab();
		for (int i = 0; i < n; i++) begin
			d = {$urandom, $urandom};
			p = par(d) ^ {3'h0, bad};
			rxq.push_back({d, p, 4'h0, bad});
			ag.beat(d, p);
		end
		ag.release_bus();
	endtask

	// Capture what the postponement flop should hold.
	always @(posedge clk) begin
		post_exp <= ~completion_postponed_n;
		chk_ok <= !sys_rst;
	end

	// Watch the pins and the receive side.
	always @(negedge clk) begin
		if (!sys_rst && chk_ok)
			chk(rx_postponed, post_exp);
		if (a_oe)
			chk(data_n_oe, 1'b0);
		if (data_n_oe && !data_valid_n_in) begin
			chk(data_bus_in_use_n_in, 1'b0);
			exp_tx = txq.size() ? txq.pop_front() : 'x;
			chk({data_n_in, data_parity_n_in, data_invert_n_in}, exp_tx);
		end
		if (rx_valid)
			chk({rx_beat, rx_parity_err}, rxq.size() ? rxq.pop_front() : 'x);
	end

	// Alternating ownership between the core and the far agent, then a contested start.
	initial begin
		void'($urandom(32'hbe31));
		repeat (4) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		for (int r = 0; r < 6; r++) begin
			tx_send(1 + $urandom % 4);
			wait_free();
			ag_send(1 + $urandom % 3, r == 3);
		end
		wait_free();
		fork
			tx_send(2);
		join_none
		ag_send(2, 1'b0);
		wait fork;
		repeat (4) @(posedge clk);
		chk(txq.size() + rxq.size(), 0);
		stop_test();
	end
endmodule

`default_nettype wire

// ### logic/sbd_data_phase.sv
`timescale 1ns/10ps
`default_nettype none

module sbd_data_phase (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// Core send side.
	input  wire logic                 tx_req,
	input  wire logic                 tx_valid,
	input  wire logic [63:0]          tx_data,
	input  wire logic [3:0]           tx_invert,
	input  wire logic                 tx_last,
	output logic                      tx_ready,
	output logic                      tx_owned,
	// Core receive side.
	output var sbd_pkg::sbd_beat_type rx_beat,
	output logic                      rx_valid,
	output logic                      rx_parity_err,
	output logic                      rx_postponed,
	// Bus pins, split into input, output and output enable.
	input  wire logic [63:0]          data_n_in,
	output logic      [63:0]          data_n_out,
	output logic                      data_n_oe,
	input  wire logic [3:0]           data_parity_n_in,
	output logic      [3:0]           data_parity_n_out,
	output logic                      data_parity_n_oe,
	input  wire logic [3:0]           data_invert_n_in,
	output logic      [3:0]           data_invert_n_out,
	output logic                      data_invert_n_oe,
	input  wire logic                 data_valid_n_in,
	output logic                      data_valid_n_out,
	output logic                      data_valid_n_oe,
	input  wire logic                 data_bus_in_use_n_in,
	output logic                      data_bus_in_use_n_out,
	output logic                      data_bus_in_use_n_oe,
	input  wire logic                 completion_postponed_n
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_OWN
	} sbd_state_type;

	sbd_state_type     state_ff;
	sbd_state_type     nxt_state;
	wire logic [63:0]  coded_data;
	wire logic [3:0]   coded_par;
	logic [63:0]       data_out_ff;
	logic [3:0]        par_out_ff;
	logic [3:0]        inv_out_ff;
	logic              valid_out_ff;
	logic              busy_out_ff;
	logic              finish_ff;
	logic              bus_free;
	logic              beat_go;
	logic [3:0]        rx_par_chk;

	// Per-group inversion and parity for the outgoing beat.
	genvar g;
	generate
		for (g = 0; g < sbd_pkg::GROUPS; g++) begin : g_grp
			sbd_group_par #(.WIDTH(sbd_pkg::GROUP_W)) u_par (
				.grp_data (tx_data[g*sbd_pkg::GROUP_W +: sbd_pkg::GROUP_W]),
				.grp_inv  (tx_invert[g]),
				.grp_out  (coded_data[g*sbd_pkg::GROUP_W +: sbd_pkg::GROUP_W]),
				.grp_par  (coded_par[g])
			);
		end
	endgenerate

	// The lines are free only once no other agent holds bus-in-use.
	assign bus_free = data_bus_in_use_n_in;
	assign beat_go  = (state_ff == ST_OWN) && tx_valid && !finish_ff;
	assign tx_ready = (state_ff == ST_OWN) && !finish_ff;
	assign tx_owned = (state_ff == ST_OWN);

	// Ownership sequencing: wait for release, own, then release after the last beat.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (tx_req) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (bus_free) begin
					nxt_state = ST_OWN;
				end
			end
			ST_OWN: begin
				if (finish_ff) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Last beat marks the end of ownership in the following clock.
	always_ff @(posedge clk) begin
		if (sys_rst || state_ff != ST_OWN) begin
			finish_ff <= 1'b0;
		end else if (beat_go && tx_last) begin
			finish_ff <= 1'b1;
		end
	end

	// Bus-in-use is held low for every clock of ownership.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_out_ff <= 1'b0;
		end else begin
			busy_out_ff <= (nxt_state == ST_OWN);
		end
	end

	// Outgoing beat; a clock without tx_valid becomes an idle clock.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_out_ff  <= sbd_pkg::DATA_RST;
			par_out_ff   <= sbd_pkg::NIB_RST;
			inv_out_ff   <= sbd_pkg::NIB_RST;
			valid_out_ff <= 1'b0;
		end else begin
			valid_out_ff <= beat_go;
			if (beat_go) begin
				data_out_ff <= ~coded_data;
				par_out_ff  <= ~coded_par;
				inv_out_ff  <= ~tx_invert;
			end
		end
	end

	// Pin drive; every line is driven only while this agent owns the bus.
	assign data_n_out            = data_out_ff;
	assign data_parity_n_out     = par_out_ff;
	assign data_invert_n_out     = inv_out_ff;
	assign data_valid_n_out      = ~valid_out_ff;
	assign data_bus_in_use_n_out = ~busy_out_ff;
	assign data_n_oe             = busy_out_ff;
	assign data_parity_n_oe      = busy_out_ff;
	assign data_invert_n_oe      = busy_out_ff;
	assign data_valid_n_oe       = busy_out_ff;
	assign data_bus_in_use_n_oe  = busy_out_ff;

	// Expected parity of each received group, taken over the wire levels.
	always_comb begin
		for (int i = 0; i < sbd_pkg::GROUPS; i++) begin
			rx_par_chk[i] = ^(~data_n_in[i*sbd_pkg::GROUP_W +: sbd_pkg::GROUP_W]);
		end
	end

	// Receive capture only on valid clocks; idle clocks leave the beat untouched.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_beat       <= '0;
			rx_valid      <= 1'b0;
			rx_parity_err <= 1'b0;
		end else begin
			rx_valid <= !data_valid_n_in && !busy_out_ff;
			if (!data_valid_n_in && !busy_out_ff) begin
				rx_beat.data   <= ~data_n_in;
				rx_beat.parity <= ~data_parity_n_in;
				rx_beat.invert <= ~data_invert_n_in;
				rx_parity_err  <= (rx_par_chk != ~data_parity_n_in);
			end
		end
	end

	// Postponement is only received; it is registered for the core.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_postponed <= 1'b0;
		end else begin
			rx_postponed <= !completion_postponed_n;
		end
	end

	// Checks.
	a_busy_covers_valid: assert property (@(posedge clk) disable iff (sys_rst)
		!data_valid_n_out |-> !data_bus_in_use_n_out)
		else $error("data valid outside bus ownership");
	a_wait_for_free: assert property (@(posedge clk) disable iff (sys_rst)
		(state_ff == ST_WAIT && !data_bus_in_use_n_in) |=> state_ff != ST_OWN)
		else $error("bus taken while another agent held it");
	a_parity_match: assert property (@(posedge clk) disable iff (sys_rst)
		beat_go |=> (~data_parity_n_out[0] == ^(~data_n_out[15:0])))
		else $error("driven parity does not match data");
	a_valid_per_beat: assert property (@(posedge clk) disable iff (sys_rst)
		beat_go |=> !data_valid_n_out)
		else $error("beat not marked valid");
	a_idle_clock: assert property (@(posedge clk) disable iff (sys_rst)
		(tx_owned && !tx_valid) |=> data_valid_n_out)
		else $error("idle clock marked valid");
	a_invert_group: assert property (@(posedge clk) disable iff (sys_rst)
		(beat_go && tx_invert[3]) |=> (data_n_out[63:48] == $past(tx_data[63:48])))
		else $error("group three inversion wrong");
	a_rx_capture: assert property (@(posedge clk) disable iff (sys_rst)
		(data_valid_n_in && !busy_out_ff) |=> (!rx_valid && $stable(rx_beat)))
		else $error("captured on idle clock");
	a_postpone_pass: assert property (@(posedge clk) disable iff (sys_rst)
		!completion_postponed_n |=> rx_postponed)
		else $error("postponement lost");
	c_own: cover property (@(posedge clk) state_ff == ST_WAIT ##1 state_ff == ST_OWN);
	c_gap: cover property (@(posedge clk) beat_go ##1 (tx_owned && !tx_valid) ##1 beat_go);
	c_rx: cover property (@(posedge clk) rx_valid ##1 !rx_valid ##1 rx_valid);

endmodule

`default_nettype wire

// ### logic/sbd_group_par.sv
`timescale 1ns/10ps
`default_nettype none

// Parity over one 16-bit group of data lines, with the optional inversion applied.
module sbd_group_par #(
	parameter int WIDTH = 16
) (
	// Raw group data and inversion request.
	input  wire logic [WIDTH-1:0] grp_data,
	input  wire logic             grp_inv,
	// Coded group and its parity bit.
	output logic      [WIDTH-1:0] grp_out,
	output logic                  grp_par
);

	// Inversion flips the whole group; parity covers the data as it appears on the wire.
	assign grp_out = grp_inv ? ~grp_data : grp_data;
	assign grp_par = ^grp_out;

endmodule

`default_nettype wire

// ### logic/sbd_pkg.sv
package sbd_pkg;

	// Bus geometry.
	localparam int DATA_W   = 64;
	localparam int GROUPS   = 4;
	localparam int GROUP_W  = 16;

	// Values after reset.
	localparam logic [63:0] DATA_RST = 64'h0;
	localparam logic [3:0]  NIB_RST  = 4'hf;

	// One beat of data with its parity and inversion lines, active high inside the block.
	typedef struct packed {
		logic [63:0] data;
		logic [3:0]  parity;
		logic [3:0]  invert;
	} sbd_beat_type;

endpackage
